// ### hdl/irqlf_map.vh
// Register addresses, flag positions and mask defaults of the first request channel.
`ifndef IRQLF_MAP_VH
`define IRQLF_MAP_VH
`define IRQLF_ADDR_W 16
`define IRQLF_DATA_W 16
`define IRQLF_ADDR_SPKR 16'h0d01
`define IRQLF_ADDR_CLKEV 16'h0d02
`define IRQLF_ADDR_PATH 16'h0d03
`define IRQLF_ADDR_OUTD 16'h0d04
`define IRQLF_ADDR_IM_SPKR 16'h0d09
`define IRQLF_ADDR_IM_CLKEV 16'h0d0a
`define IRQLF_ADDR_IM_PATH 16'h0d0b
`define IRQLF_ADDR_IM_OUTD 16'h0d0c
// Implemented bit positions of each flag register.
`define IRQLF_SPKR_USED 16'hf000
`define IRQLF_CLKEV_USED 16'hfbef
`define IRQLF_PATH_USED 16'h1f8f
`define IRQLF_OUTD_USED 16'h7f0a
// Bits triggered on both edges; the rest, apart from the pulse bits, take the rising edge only.
`define IRQLF_SPKR_BOTH 16'h0000
`define IRQLF_CLKEV_BOTH 16'hc38c
`define IRQLF_PATH_BOTH 16'h0000
`define IRQLF_OUTD_BOTH 16'h0002
// Bits set by a one-cycle event pulse rather than an edge.
`define IRQLF_CLKEV_PULSE 16'h1000
// Mask resets: everything masked except the startup complete input.
`define IRQLF_IM_RST 16'hffff
`define IRQLF_IM_OUTD_RST 16'hfeff
`define IRQLF_ZERO 16'h0000
`endif

// ### hdl/irqlf_flag_reg.v
// One 16-bit latched flag register with edge detect, mask and write-one-to-clear.
`timescale 1ns/10ps
module irqlf_flag_reg #(
  parameter W = 16,
  parameter [W-1:0] USED = {W{1'b1}},
  parameter [W-1:0] BOTH = {W{1'b0}},
  parameter [W-1:0] PULSE = {W{1'b0}},
  parameter [W-1:0] MASK_RST = {W{1'b1}}
) (
  clk,
  rstn,
  src,
  mask_we,
  clr_we,
  wdata,
  flags,
  mask
);
  input wire clk;
  input wire rstn;
  input wire [W-1:0] src;
  input wire mask_we;
  input wire clr_we;
  input wire [W-1:0] wdata;
  output reg [W-1:0] flags;
  output reg [W-1:0] mask;

  reg [W-1:0] src_q;
  wire [W-1:0] rise;
  wire [W-1:0] fall;
  wire [W-1:0] event_hit;
  wire [W-1:0] clr;

  assign rise = src & ~src_q;
  assign fall = ~src & src_q;
  // Both-edge bits see either transition, pulse bits see the event itself.
  assign event_hit = USED & ~mask & ((PULSE & src) | (~PULSE & (rise | (BOTH & fall))));
  assign clr = (clr_we ? wdata : {W{1'b0}}) & USED;

  always @(posedge clk) begin
    if (!rstn) begin
      src_q <= {W{1'b0}};
      flags <= {W{1'b0}};
      mask <= MASK_RST;
    end else begin
      src_q <= src;
      flags <= (flags & ~clr) | event_hit;
      if (mask_we) begin
        mask <= wdata;
      end
    end
  end
endmodule

// ### hdl/irqlf_top.v
// Latched event flags of the first interrupt request channel with mask and request output.
`timescale 1ns/10ps
`include "irqlf_map.vh"
module irqlf_top (
  clk,
  rstn,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  spk_ramp_src,
  spk_heat_warning,
  spk_heat_shutdown,
  headphone_sense,
  accessory_detect_evt,
  sequencer_finished,
  dynamics_signal,
  rate_conv_b_lock,
  rate_conv_a_lock,
  clock_too_slow,
  clock_too_fast,
  loop_b_lock,
  loop_a_lock,
  main_clock_slow,
  async_clock_slow,
  host_port_error,
  mixer_sample_loss,
  async_domain_ena,
  main_domain_ena,
  int_conv_a_cfg,
  int_conv_b_cfg,
  line_right_on,
  line_left_on,
  phones_right_on,
  phones_left_on,
  earpiece_on,
  earpiece_off,
  line_right_off,
  line_left_off,
  phones_right_off,
  phones_left_off,
  startup_complete,
  async_conv_cfg,
  loop_b_clock_good,
  first_request_output
);
  input wire clk;
  input wire rstn;
  input wire [`IRQLF_ADDR_W-1:0] reg_addr;
  input wire reg_wr;
  input wire reg_rd;
  input wire [`IRQLF_DATA_W-1:0] reg_wdata;
  output reg [`IRQLF_DATA_W-1:0] reg_rdata;
  input wire [3:0] spk_ramp_src;
  input wire spk_heat_warning;
  input wire spk_heat_shutdown;
  input wire headphone_sense;
  input wire accessory_detect_evt;
  input wire sequencer_finished;
  input wire dynamics_signal;
  input wire rate_conv_b_lock;
  input wire rate_conv_a_lock;
  input wire clock_too_slow;
  input wire clock_too_fast;
  input wire loop_b_lock;
  input wire loop_a_lock;
  input wire main_clock_slow;
  input wire async_clock_slow;
  input wire host_port_error;
  input wire mixer_sample_loss;
  input wire async_domain_ena;
  input wire main_domain_ena;
  input wire int_conv_a_cfg;
  input wire int_conv_b_cfg;
  input wire line_right_on;
  input wire line_left_on;
  input wire phones_right_on;
  input wire phones_left_on;
  input wire earpiece_on;
  input wire earpiece_off;
  input wire line_right_off;
  input wire line_left_off;
  input wire phones_right_off;
  input wire phones_left_off;
  input wire startup_complete;
  input wire async_conv_cfg;
  input wire loop_b_clock_good;
  output reg first_request_output;

  localparam W = `IRQLF_DATA_W;

  wire [W-1:0] spkr_src;
  wire [W-1:0] clkev_src;
  wire [W-1:0] path_src;
  wire [W-1:0] outd_src;
  wire [W-1:0] spkr_flags;
  wire [W-1:0] clkev_flags;
  wire [W-1:0] path_flags;
  wire [W-1:0] outd_flags;
  wire [W-1:0] spkr_mask;
  wire [W-1:0] clkev_mask;
  wire [W-1:0] path_mask;
  wire [W-1:0] outd_mask;
  wire [W-1:0] spkr_sync;
  wire [W-1:0] clkev_sync;
  wire [W-1:0] path_sync;
  wire [W-1:0] outd_sync;
  reg [4*W-1:0] meta_q;
  reg [4*W-1:0] sync_q;

  assign spkr_src = {spk_ramp_src, 12'h000};
  assign clkev_src = {spk_heat_warning, spk_heat_shutdown,
    headphone_sense, accessory_detect_evt, sequencer_finished,
    1'b0, dynamics_signal, rate_conv_b_lock, rate_conv_a_lock,
    clock_too_slow, clock_too_fast, 1'b0,
    loop_b_lock, loop_a_lock, main_clock_slow, async_clock_slow};
  // Domain stop flags watch the inverted enables so only shut-down counts.
  assign path_src = {3'h0, host_port_error, mixer_sample_loss,
    ~async_domain_ena, ~main_domain_ena, int_conv_a_cfg, int_conv_b_cfg,
    3'h0, line_right_on, line_left_on, phones_right_on, phones_left_on};
  assign outd_src = {1'b0, earpiece_on, earpiece_off,
    line_right_off, line_left_off, phones_right_off, phones_left_off,
    startup_complete, 4'h0, async_conv_cfg, 1'b0, loop_b_clock_good, 1'b0};

  // Every source comes from outside this clock domain and passes two flip-flops.
  always @(posedge clk) begin
    if (!rstn) begin
      meta_q <= {4*W{1'b0}};
      sync_q <= {4*W{1'b0}};
    end else begin
      meta_q <= {spkr_src, clkev_src, path_src, outd_src};
      sync_q <= meta_q;
    end
  end

  assign spkr_sync = sync_q[4*W-1:3*W];
  assign clkev_sync = sync_q[3*W-1:2*W];
  assign path_sync = sync_q[2*W-1:W];
  assign outd_sync = sync_q[W-1:0];

  irqlf_flag_reg #(.W(W), .USED(`IRQLF_SPKR_USED), .BOTH(`IRQLF_SPKR_BOTH),
    .PULSE(`IRQLF_ZERO), .MASK_RST(`IRQLF_IM_RST)) u_spkr (
    .clk(clk),
    .rstn(rstn),
    .src(spkr_sync),
    .mask_we(reg_wr && reg_addr == `IRQLF_ADDR_IM_SPKR),
    .clr_we(reg_wr && reg_addr == `IRQLF_ADDR_SPKR),
    .wdata(reg_wdata),
    .flags(spkr_flags),
    .mask(spkr_mask)
  );

  irqlf_flag_reg #(.W(W), .USED(`IRQLF_CLKEV_USED), .BOTH(`IRQLF_CLKEV_BOTH),
    .PULSE(`IRQLF_CLKEV_PULSE), .MASK_RST(`IRQLF_IM_RST)) u_clkev (
    .clk(clk),
    .rstn(rstn),
    .src(clkev_sync),
    .mask_we(reg_wr && reg_addr == `IRQLF_ADDR_IM_CLKEV),
    .clr_we(reg_wr && reg_addr == `IRQLF_ADDR_CLKEV),
    .wdata(reg_wdata),
    .flags(clkev_flags),
    .mask(clkev_mask)
  );

  irqlf_flag_reg #(.W(W), .USED(`IRQLF_PATH_USED), .BOTH(`IRQLF_PATH_BOTH),
    .PULSE(`IRQLF_ZERO), .MASK_RST(`IRQLF_IM_RST)) u_path (
    .clk(clk),
    .rstn(rstn),
    .src(path_sync),
    .mask_we(reg_wr && reg_addr == `IRQLF_ADDR_IM_PATH),
    .clr_we(reg_wr && reg_addr == `IRQLF_ADDR_PATH),
    .wdata(reg_wdata),
    .flags(path_flags),
    .mask(path_mask)
  );

  irqlf_flag_reg #(.W(W), .USED(`IRQLF_OUTD_USED), .BOTH(`IRQLF_OUTD_BOTH),
    .PULSE(`IRQLF_ZERO), .MASK_RST(`IRQLF_IM_OUTD_RST)) u_outd (
    .clk(clk),
    .rstn(rstn),
    .src(outd_sync),
    .mask_we(reg_wr && reg_addr == `IRQLF_ADDR_IM_OUTD),
    .clr_we(reg_wr && reg_addr == `IRQLF_ADDR_OUTD),
    .wdata(reg_wdata),
    .flags(outd_flags),
    .mask(outd_mask)
  );

  // Read data is registered; unmapped addresses and unused flag bits read zero, while all 16 mask bits read back as written.
  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= `IRQLF_ZERO;
      first_request_output <= 1'b0;
    end else begin
      first_request_output <= |{spkr_flags, clkev_flags, path_flags, outd_flags};
      if (reg_rd) begin
        case (reg_addr)
          `IRQLF_ADDR_SPKR: reg_rdata <= spkr_flags;
          `IRQLF_ADDR_CLKEV: reg_rdata <= clkev_flags;
          `IRQLF_ADDR_PATH: reg_rdata <= path_flags;
          `IRQLF_ADDR_OUTD: reg_rdata <= outd_flags;
          `IRQLF_ADDR_IM_SPKR: reg_rdata <= spkr_mask;
          `IRQLF_ADDR_IM_CLKEV: reg_rdata <= clkev_mask;
          `IRQLF_ADDR_IM_PATH: reg_rdata <= path_mask;
          `IRQLF_ADDR_IM_OUTD: reg_rdata <= outd_mask;
          default: reg_rdata <= `IRQLF_ZERO;
        endcase
      end
    end
  end
endmodule

// ### verification/irqlf_assertions.sv
// Assertions on the first request channel ports.
`timescale 1ns/10ps
`include "irqlf_map.vh"
module irqlf_chk (
  input wire clk,
  input wire rstn,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire startup_complete,
  input wire first_request_output
);
  reg tch_q;
  reg boot_q;
  reg im_q;
  wire clr = reg_wr && reg_wdata != 16'h0000 && reg_addr inside {[16'h0d01:16'h0d04]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  always @(posedge clk) begin
    if (!rstn) begin
      tch_q <= 1'b0;
      boot_q <= 1'b0;
      im_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 16'h0d0c) tch_q <= 1'b1;
      if (reg_wr && reg_addr inside {[16'h0d09:16'h0d0c]}) im_q <= 1'b1;
      if (startup_complete) boot_q <= 1'b1;
    end
  end
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  sequence s_boot; $rose(startup_complete) && !tch_q; endsequence
  property p_rst; $rose(rstn) |-> reg_rdata == 16'h0000 && !first_request_output; endproperty
  property p_unmap;
    reg_rd && !(reg_addr inside {[16'h0d01:16'h0d04], [16'h0d09:16'h0d0c]})
      |=> reg_rdata == 16'h0000;
  endproperty
  property p_clkev; s_rd(`IRQLF_ADDR_CLKEV) |=> (reg_rdata & ~`IRQLF_CLKEV_USED) == 0; endproperty
  property p_path; s_rd(`IRQLF_ADDR_PATH) |=> (reg_rdata & ~`IRQLF_PATH_USED) == 0; endproperty
  property p_hold;
    first_request_output && !reg_wr && !$past(reg_wr) |=> first_request_output;
  endproperty
  property p_fall; $fell(first_request_output) |-> $past(clr, 2); endproperty
  property p_boot; s_boot |-> ##[3:5] first_request_output; endproperty
  property p_mask; !im_q && !boot_q |-> !first_request_output; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_clkev: assert property (p_clkev) else $error("unused clock event bit set");
  a_path: assert property (p_path) else $error("unused path bit set");
  a_hold: assert property (p_hold) else $error("request dropped without write");
  a_fall: assert property (p_fall) else $error("request fell without clear");
  a_boot: assert property (p_boot) else $error("startup event gave no request");
  a_mask: assert property (p_mask) else $error("masked input raised request");
endmodule
bind irqlf_top irqlf_chk irqlf_chk_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .startup_complete(startup_complete), .first_request_output(first_request_output));

// ### verification/irqlf_host.sv
// Host software model driving the register port.
`timescale 1ns/10ps
module irqlf_host (
  input wire clk,
  output reg [15:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [15:0] reg_wdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// ### verification/tb_irqlf_top.sv
// Self-checking bench for the first request channel flags.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_irqlf_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [63:0] s = 64'h0000_0600_0000_0000;
  wire [15:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, req;
  logic [15:0] q[$];
  logic [15:0] tg[4] = '{16'hf000, 16'hfbef, 16'h1f8f, 16'h7f0a};
  logic [15:0] bt[4] = '{16'h0000, 16'hd38c, 16'h0000, 16'h0002};
  logic [15:0] a, e, ev;
  logic rd_q = 1'b0;
  int fails = 0, checks = 0, seed = 36, i, r, b, k;
  always #5 clk = ~clk;
  irqlf_host irqlf_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  irqlf_top irqlf_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spk_ramp_src(s[15:12]),
    .spk_heat_warning(s[31]), .spk_heat_shutdown(s[30]), .headphone_sense(s[29]),
    .accessory_detect_evt(s[28]), .sequencer_finished(s[27]), .dynamics_signal(s[25]),
    .rate_conv_b_lock(s[24]), .rate_conv_a_lock(s[23]), .clock_too_slow(s[22]),
    .clock_too_fast(s[21]), .loop_b_lock(s[19]), .loop_a_lock(s[18]),
    .main_clock_slow(s[17]), .async_clock_slow(s[16]), .host_port_error(s[44]),
    .mixer_sample_loss(s[43]), .async_domain_ena(s[42]), .main_domain_ena(s[41]),
    .int_conv_a_cfg(s[40]), .int_conv_b_cfg(s[39]), .line_right_on(s[35]),
    .line_left_on(s[34]), .phones_right_on(s[33]), .phones_left_on(s[32]),
    .earpiece_on(s[62]), .earpiece_off(s[61]), .line_right_off(s[60]),
    .line_left_off(s[59]), .phones_right_off(s[58]), .phones_left_off(s[57]),
    .startup_complete(s[56]), .async_conv_cfg(s[51]), .loop_b_clock_good(s[49]),
    .first_request_output(req));
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task rdx(input logic [15:0] ad, input logic [15:0] ex);
    q.push_back(ex);
    irqlf_host_inst.acc(1'b0, ad, 16'h0000);
  endtask
  task wr(input logic [15:0] ad, input logic [15:0] d);
    irqlf_host_inst.acc(1'b1, ad, d);
  endtask
  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_q) begin
      ev = q.pop_front();
      `CHK("rdata", ev, reg_rdata)
    end
    rd_q <= reg_rd;
  end
  initial begin
    #1000000;
    fails++;
    finish_test;
  end
  initial begin
    wt(3);
    rstn <= 1'b1;
    for (r = 1; r < 5; r++) rdx(16'h0d00 + 16'(r), 16'h0000);
    rdx(16'h0d0c, 16'hfeff);
    rdx(16'h0d0a, 16'hffff);
    rdx(16'h0d07, 16'h0000);
    for (k = 0; k < 2; k++) begin
      s <= s ^ 64'h7e0a_1f8f_fbef_f000;
      wt(6);
      for (r = 1; r < 5; r++) rdx(16'h0d00 + 16'(r), 16'h0000);
      `CHK("req", 1'b0, req)
    end
    s[56] <= 1'b1;
    wt(6);
    rdx(16'h0d04, 16'h0100);
    `CHK("req", 1'b1, req)
    wr(16'h0d04, 16'h0000);
    rdx(16'h0d04, 16'h0100);
    wr(16'h0d04, 16'h0100);
    s[56] <= 1'b0;
    rdx(16'h0d04, 16'h0000);
    `CHK("req", 1'b0, req)
    for (r = 9; r < 13; r++) wr(16'h0d00 + 16'(r), 16'h0000);
    for (i = 12; i < 64; i++) if (tg[i/16][i%16]) begin
      r = i / 16;
      b = i % 16;
      a = 16'h0d01 + 16'(r);
      for (k = 0; k < 2; k++) begin
        if (i == 28) s[i] <= 1'b1;
        else s[i] <= ~s[i];
        wt(1);
        if (i == 28) s[i] <= 1'b0;
        wt(5);
        e = (k == 0 || bt[r][b]) ? 16'h0001 << b : 16'h0000;
        rdx(a, e);
        `CHK("req", e != 16'h0000, req)
        wr(a, 16'($random(seed)) & ~e);
        rdx(a, e);
        wr(a, e);
        rdx(a, 16'h0000);
        `CHK("req", 1'b0, req)
      end
    end
    wr(16'h0d0a, 16'h0800);
    s[27] <= 1'b1;
    wt(6);
    rdx(16'h0d02, 16'h0000);
    `CHK("req", 1'b0, req)
    wt(3);
    finish_test;
  end
endmodule
